// ---- rtl/wake_agg_map.svh ----
// register offsets, field positions, reset values and timing counts
// of the interrupt and wake event aggregator
// assumes byte-wide runtime register access at the offsets below
`ifndef WAKE_AGG_MAP_SVH
`define WAKE_AGG_MAP_SVH

`define WAKE_GLOBAL_STS_OFS   8'h00
`define WAKE_GLOBAL_EN_OFS    8'h01
`define WAKE_STS_BASE_OFS     8'h03
`define WAKE_EN_BASE_OFS      8'h0B
`define SYS_STS_BASE_OFS      8'h13
`define SYS_EN_BASE_OFS       8'h1B
`define WAKE_KEY_CODE_OFS     8'h5F
`define SLOW_CLOCK_CFG_OFS    8'hF0

`define SYS_EN2_PIN_BIT       7
`define SYS_EN2_SERIRQ_BIT    6
`define SYS_EN2_ROUTE_BIT     5
`define ROUTED_IRQ_BIT        3
`define KEY_MATCH_BIT         5
`define CFG_CLK_SEL_BIT       0
`define CFG_KEY_OFF_BIT       1

`define REG_RESET             8'h00
`define KEY_CODE_RESET        8'h00
`define CFG_RESET             8'h00

`define CLK_HZ                10000000
`define SLOW_HZ               32768
`define KEY_IDLE_TICKS        4'h4

`endif

// ---- rtl/wake_agg_pkg.sv ----
// types shared by the interrupt and wake event aggregator
// assumes nothing of its surroundings
package wake_agg_pkg;

  typedef enum logic [1:0] {
    KEY_IDLE,
    KEY_SHIFT,
    KEY_CHECK
  } key_state_t;

endpackage : wake_agg_pkg

// ---- rtl/smi_pme_wake_event_aggregator.sv ----
// group interrupt and wake event aggregator with wake-on-key detector
// assumes one 10 MHz clock, byte register port, pins sampled through two flops
//
// Functional notes
// - group interrupt is OR of all enabled events over five enable registers
// - group interrupt reaches its pin only while enable two bit 7 set
// - group interrupt drives serial irq slot 2 when enable two bit 6 set
// - group interrupt feeds wake logic via routed status when bit 5 set
// - irq pin level from polarity input, drive type from push-pull input, default low open-drain
// - pin events latch on rising edge, falling if inverted, both in either-edge mode
// - pin event status cleared by writing 1, gated with enable into interrupt
// - peripheral status follows source; infrared status clears on reading status two
// - peripheral live events gate directly with enables, no latch
// - wake sources: ring indicators, infrared frames, key, mouse, pins, fan
// - wake pin level from polarity input, drive type from push-pull input
// - wake pin never asserts while global wake enable is clear
// - global wake status set by any enabled source regardless of global enable
// - global wake status stays set while any enabled event stays pending
// - pin wake status latches on selected edge, cleared by writing 1
// - routed status bit 3 latches routed group interrupt, cleared by writing 1
// - wake pin asserts when routed enable and routed status both set and global wake enable set
// - key code register at 0x5F reset only by standby reset
// - key match sets wake status one bit 5; wake needs enable bit 5
// - config bit 0 picks external slow clock or internal divided clock
// - config bit 1 set turns detector off and stops its clock ticks
`include "wake_agg_map.svh"
`timescale 1ns/1ns
`default_nettype none

module smi_pme_wake_event_aggregator (
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_standby_rstn,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  input  wire logic [14:0] i_periph_evt,
  input  wire logic        i_ir_irq,
  input  wire logic [23:0] i_gpio_evt,
  input  wire logic [23:0] i_pin_invert,
  input  wire logic [23:0] i_pin_either_edge,
  input  wire logic        i_ring_indicator_one_n,
  input  wire logic        i_ring_indicator_two_n,
  input  wire logic        i_ir_frame_ok,
  input  wire logic        i_kb_clk,
  input  wire logic        i_kb_data,
  input  wire logic        i_mouse_data,
  input  wire logic        i_fan_evt,
  input  wire logic        i_ext_slow_clk,
  input  wire logic        i_irq_pin_sel,
  input  wire logic        i_irq_pin_active_high,
  input  wire logic        i_irq_pin_push_pull,
  input  wire logic        i_wake_pin_sel,
  input  wire logic        i_wake_pin_active_high,
  input  wire logic        i_wake_pin_push_pull,
  output logic [7:0]       o_reg_rdata,
  output logic             o_group_irq_internal,
  output logic             o_irq_pin_out,
  output logic             o_irq_pin_oe_n,
  output logic             o_serirq_slot2,
  output logic             o_wake_pin_out,
  output logic             o_wake_pin_oe_n
);

  localparam int SLOW_DIV = `CLK_HZ / `SLOW_HZ;

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  localparam int NSYNC = 30;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  logic [NSYNC-1:0] prev_q;

  assign raw_in = {i_ext_slow_clk, i_mouse_data, i_kb_data, i_kb_clk,
                   i_ring_indicator_two_n, i_ring_indicator_one_n, i_gpio_evt};

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  logic [23:0] pin_s;
  logic [23:0] pin_p;
  logic        ring1_s, ring2_s, kbc_s, kbd_s, mouse_s, slow_s;
  logic        ring1_p, ring2_p, kbd_p, mouse_p, slow_p;

  assign pin_s   = sync2_q[23:0];
  assign pin_p   = prev_q[23:0];
  assign ring1_s = sync2_q[24];
  assign ring2_s = sync2_q[25];
  assign kbc_s   = sync2_q[26];
  assign kbd_s   = sync2_q[27];
  assign mouse_s = sync2_q[28];
  assign slow_s  = sync2_q[29];
  assign ring1_p = prev_q[24];
  assign ring2_p = prev_q[25];
  assign kbd_p   = prev_q[27];
  assign mouse_p = prev_q[28];
  assign slow_p  = prev_q[29];

  // ****************************************************************
  // pin edge selection
  // ****************************************************************
  logic [23:0] pin_hit;

  genvar g;
  generate
    for (g = 0; g < 24; g++) begin : g_pin
      logic rise, fall;
      assign rise = pin_s[g] & ~pin_p[g];
      assign fall = ~pin_s[g] & pin_p[g];
      assign pin_hit[g] = i_pin_either_edge[g] ? (rise | fall)
                        : (i_pin_invert[g] ? fall : rise);
    end
  endgenerate

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [5:1][7:0] sys_en_q;
  logic [5:1][7:0] wake_en_q;
  logic [5:3][7:0] sys_pin_sts_q;
  logic [5:1][7:0] wake_sts_q;
  logic [5:1][7:0] sys_sts;
  logic [5:1][7:0] wake_set;
  logic            ir_sts_q, gwake_sts_q, gwake_en_q;
  logic [7:0]      key_code_q;
  logic [7:0]      cfg_q;
  logic            key_hit_q, group_irq;

  function automatic logic wr_at(input logic [7:0] ofs);
    wr_at = i_reg_wr && (i_reg_addr == ofs);
  endfunction

  assign sys_sts[1] = i_periph_evt[7:0];
  assign sys_sts[2] = {i_periph_evt[14:8], ir_sts_q};
  assign sys_sts[3] = sys_pin_sts_q[3];
  assign sys_sts[4] = sys_pin_sts_q[4];
  assign sys_sts[5] = sys_pin_sts_q[5];

  // group interrupt: peripheral events gated live, pin events latched
  always_comb begin
    group_irq = 1'b0;
    for (int i = 1; i <= 5; i++) begin
      group_irq = group_irq | (|(sys_sts[i] & sys_en_q[i]));
    end
  end

  // wake sources per status bit
  assign wake_set[1] = {1'b0,
                        i_fan_evt,
                        key_hit_q,
                        mouse_p & ~mouse_s,
                        kbd_p & ~kbd_s,
                        i_ir_frame_ok,
                        ring2_p & ~ring2_s,
                        ring1_p & ~ring1_s};
  assign wake_set[2] = pin_hit[7:0];
  assign wake_set[3] = {4'h0, group_irq & sys_en_q[2][`SYS_EN2_ROUTE_BIT], 3'h0};
  assign wake_set[4] = pin_hit[15:8];
  assign wake_set[5] = pin_hit[23:16];

  // ****************************************************************
  // enable and configuration registers
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sys_en_q   <= '0;
      wake_en_q  <= '0;
      gwake_en_q <= 1'b0;
      cfg_q      <= `CFG_RESET;
    end else begin
      for (int i = 1; i <= 5; i++) begin
        if (wr_at(8'(`SYS_EN_BASE_OFS + i - 1))) begin
          sys_en_q[i] <= i_reg_wdata;
        end
        if (wr_at(8'(`WAKE_EN_BASE_OFS + i - 1))) begin
          wake_en_q[i] <= i_reg_wdata;
        end
      end
      if (wr_at(`WAKE_GLOBAL_EN_OFS)) begin
        gwake_en_q <= i_reg_wdata[0];
      end
      if (wr_at(`SLOW_CLOCK_CFG_OFS)) begin
        cfg_q <= i_reg_wdata;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_standby_rstn) begin
      key_code_q <= `KEY_CODE_RESET;
    end else if (wr_at(`WAKE_KEY_CODE_OFS)) begin
      key_code_q <= i_reg_wdata;
    end
  end

  // ****************************************************************
  // status registers, set wins over clear
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sys_pin_sts_q <= '0;
      wake_sts_q    <= '0;
    end else begin
      for (int i = 3; i <= 5; i++) begin
        sys_pin_sts_q[i] <= (sys_pin_sts_q[i]
                            & ~(wr_at(8'(`SYS_STS_BASE_OFS + i - 1)) ? i_reg_wdata : 8'h00))
                            | pin_hit[(i-3)*8 +: 8];
      end
      for (int i = 1; i <= 5; i++) begin
        wake_sts_q[i] <= (wake_sts_q[i]
                         & ~(wr_at(8'(`WAKE_STS_BASE_OFS + i - 1)) ? i_reg_wdata : 8'h00))
                         | wake_set[i];
      end
    end
  end

  // infrared status clears on a read of system status two
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      ir_sts_q <= 1'b0;
    end else if (i_ir_irq) begin
      ir_sts_q <= 1'b1;
    end else if (i_reg_rd && i_reg_addr == 8'(`SYS_STS_BASE_OFS + 1)) begin
      ir_sts_q <= 1'b0;
    end
  end

  // ****************************************************************
  // global wake status
  // ****************************************************************
  logic wake_pending, wake_new;

  always_comb begin
    wake_pending = 1'b0;
    wake_new     = 1'b0;
    for (int i = 1; i <= 5; i++) begin
      wake_pending = wake_pending | (|(wake_sts_q[i] & wake_en_q[i]));
      wake_new     = wake_new | (|(wake_set[i] & wake_en_q[i]));
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      gwake_sts_q <= 1'b0;
    end else if (wake_new || wake_pending) begin
      gwake_sts_q <= 1'b1;
    end else if (wr_at(`WAKE_GLOBAL_STS_OFS) && i_reg_wdata[0]) begin
      gwake_sts_q <= 1'b0;
    end
  end

  // ****************************************************************
  // key detector clock tick
  // ****************************************************************
  logic [8:0] div_q;
  logic       int_tick, slow_tick, key_off;

  assign key_off   = cfg_q[`CFG_KEY_OFF_BIT];
  assign int_tick  = (div_q == 9'(SLOW_DIV - 1));
  assign slow_tick = ~key_off & (cfg_q[`CFG_CLK_SEL_BIT] ? (slow_s & ~slow_p)
                                                           : int_tick);

  always_ff @(posedge i_clk) begin
    if (!i_rstn || int_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 9'h001;
    end
  end

  // ****************************************************************
  // key frame receiver
  // ****************************************************************
  wake_agg_pkg::key_state_t key_st_q;
  logic [9:0]  key_sh_q;
  logic [3:0]  key_cnt_q;
  logic [3:0]  key_idle_q;
  logic        kbc_tq, kb_fall;

  assign kb_fall = kbc_tq & ~kbc_s;

  always_ff @(posedge i_clk) begin
    if (!i_rstn || key_off) begin
      key_st_q   <= wake_agg_pkg::KEY_IDLE;
      key_sh_q   <= '0;
      key_cnt_q  <= '0;
      key_idle_q <= '0;
      kbc_tq     <= 1'b1;
      key_hit_q  <= 1'b0;
    end else begin
      key_hit_q <= 1'b0;
      if (slow_tick) begin
        kbc_tq <= kbc_s;
        key_idle_q <= kb_fall ? 4'h0 : ((key_idle_q == `KEY_IDLE_TICKS) ? key_idle_q
                                                                        : key_idle_q + 4'h1);
        case (key_st_q)
          wake_agg_pkg::KEY_IDLE: begin
            if (kb_fall && !kbd_s) begin
              key_st_q  <= wake_agg_pkg::KEY_SHIFT;
              key_cnt_q <= '0;
            end
          end
          wake_agg_pkg::KEY_SHIFT: begin
            if (kb_fall) begin
              key_sh_q  <= {kbd_s, key_sh_q[9:1]};
              key_cnt_q <= key_cnt_q + 4'h1;
              if (key_cnt_q == 4'h9) begin
                key_st_q <= wake_agg_pkg::KEY_CHECK;
              end
            end else if (key_idle_q == `KEY_IDLE_TICKS) begin
              key_st_q <= wake_agg_pkg::KEY_IDLE;
            end
          end
          wake_agg_pkg::KEY_CHECK: begin
            key_hit_q <= key_sh_q[9] && (^key_sh_q[8:0])
                         && (key_sh_q[7:0] == key_code_q);
            key_st_q  <= wake_agg_pkg::KEY_IDLE;
          end
          default: begin
            key_st_q <= wake_agg_pkg::KEY_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  logic [7:0] rd_d;

  always_comb begin
    rd_d = 8'h00;
    for (int i = 1; i <= 5; i++) begin
      if (i_reg_addr == 8'(`SYS_EN_BASE_OFS + i - 1)) rd_d = sys_en_q[i];
      if (i_reg_addr == 8'(`WAKE_EN_BASE_OFS + i - 1)) rd_d = wake_en_q[i];
      if (i_reg_addr == 8'(`SYS_STS_BASE_OFS + i - 1)) rd_d = sys_sts[i];
      if (i_reg_addr == 8'(`WAKE_STS_BASE_OFS + i - 1)) rd_d = wake_sts_q[i];
    end
    if (i_reg_addr == `WAKE_GLOBAL_STS_OFS) rd_d = {7'h00, gwake_sts_q};
    if (i_reg_addr == `WAKE_GLOBAL_EN_OFS) rd_d = {7'h00, gwake_en_q};
    if (i_reg_addr == `WAKE_KEY_CODE_OFS) rd_d = key_code_q;
    if (i_reg_addr == `SLOW_CLOCK_CFG_OFS) rd_d = cfg_q;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_reg_rdata <= `REG_RESET;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rd_d;
    end
  end

  // ****************************************************************
  // output pins
  // ****************************************************************
  logic irq_act, irq_lvl, wake_act, wake_lvl;

  assign irq_act  = group_irq & sys_en_q[2][`SYS_EN2_PIN_BIT];
  assign irq_lvl  = i_irq_pin_active_high ? irq_act : ~irq_act;
  assign wake_act = gwake_en_q & gwake_sts_q;
  assign wake_lvl = i_wake_pin_active_high ? wake_act : ~wake_act;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_group_irq_internal <= 1'b0;
      o_serirq_slot2       <= 1'b0;
      o_irq_pin_out        <= 1'b0;
      o_irq_pin_oe_n       <= 1'b1;
      o_wake_pin_out       <= 1'b0;
      o_wake_pin_oe_n      <= 1'b1;
    end else begin
      o_group_irq_internal <= group_irq;
      o_serirq_slot2       <= group_irq & sys_en_q[2][`SYS_EN2_SERIRQ_BIT];
      o_irq_pin_out        <= i_irq_pin_push_pull ? irq_lvl : 1'b0;
      o_irq_pin_oe_n       <= ~i_irq_pin_sel | (~i_irq_pin_push_pull & irq_lvl);
      o_wake_pin_out       <= i_wake_pin_push_pull ? wake_lvl : 1'b0;
      o_wake_pin_oe_n      <= ~i_wake_pin_sel | (~i_wake_pin_push_pull & wake_lvl);
    end
  end

endmodule : smi_pme_wake_event_aggregator

`default_nettype wire

// ---- bench/smi_pme_wake_event_aggregator_sva.sv ----
// port assertions for the interrupt and wake event aggregator
// assumes it is bound onto the aggregator top and writes are byte wide
`include "wake_agg_map.svh"
`timescale 1ns/1ns
`default_nettype none

module agg_checker (
  input wire logic        i_clk,
  input wire logic        i_rstn,
  input wire logic        i_reg_wr,
  input wire logic        i_reg_rd,
  input wire logic [7:0]  i_reg_addr,
  input wire logic [7:0]  i_reg_wdata,
  input wire logic [14:0] i_periph_evt,
  input wire logic        i_irq_pin_sel,
  input wire logic        i_irq_pin_active_high,
  input wire logic        i_irq_pin_push_pull,
  input wire logic        i_wake_pin_active_high,
  input wire logic        i_wake_pin_push_pull,
  input wire logic [7:0]  o_reg_rdata,
  input wire logic        o_group_irq_internal,
  input wire logic        o_irq_pin_out,
  input wire logic        o_irq_pin_oe_n,
  input wire logic        o_serirq_slot2,
  input wire logic        o_wake_pin_out,
  input wire logic        o_wake_pin_oe_n
);
  // ***************************************
  // shadows of the enables seen on the port
  // ***************************************
  logic [7:0] en1_q;
  logic [7:0] en2_q;
  logic       gwen_q;

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      en1_q  <= 8'h00;
      en2_q  <= 8'h00;
      gwen_q <= 1'b0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == `SYS_EN_BASE_OFS) en1_q <= i_reg_wdata;
      if (i_reg_addr == `SYS_EN_BASE_OFS + 8'h01) en2_q <= i_reg_wdata;
      if (i_reg_addr == `WAKE_GLOBAL_EN_OFS) gwen_q <= i_reg_wdata[0];
    end
  end

  // **********
  // assertions
  // **********
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  AST_RESET_IDLE: assert property (disable iff (1'b0) !i_rstn |=> o_reg_rdata == 8'h00
    && o_irq_pin_oe_n && o_wake_pin_oe_n && !o_group_irq_internal && !o_serirq_slot2)
    else $error("outputs not idle after reset");
  AST_RDATA_HOLDS: assert property (!$past(i_reg_rd) && $past(i_rstn) |-> $stable(o_reg_rdata))
    else $error("read data moved without a read");
  AST_UNMAPPED_ZERO: assert property (i_reg_rd && i_reg_addr inside {[8'h20:8'h5E]}
    |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_PERIPH_LIVE: assert property ((en1_q[0] && i_periph_evt[0]) [*3] |-> o_group_irq_internal)
    else $error("enabled live event gives no group interrupt");
  AST_SERIRQ_GATE: assert property (o_serirq_slot2 |-> (en2_q[6] || $past(en2_q[6]))
    && (o_group_irq_internal || $past(o_group_irq_internal)))
    else $error("slot two asserted without its enable");
  AST_IRQ_PIN_GATE: assert property (!i_irq_pin_push_pull && !i_irq_pin_active_high
    && !o_irq_pin_oe_n |-> en2_q[7] || $past(en2_q[7]))
    else $error("irq pin active without its enable");
  AST_IRQ_OPEN_DRAIN: assert property (!i_irq_pin_push_pull && !$past(i_irq_pin_push_pull)
    |-> !o_irq_pin_out)
    else $error("open-drain irq pin drives high");
  AST_IRQ_PUSH_PULL: assert property (i_irq_pin_sel && i_irq_pin_push_pull
    && $past(i_irq_pin_push_pull) |-> !o_irq_pin_oe_n)
    else $error("push-pull irq pin not driven");
  AST_WAKE_OPEN_DRAIN: assert property (!i_wake_pin_push_pull && !$past(i_wake_pin_push_pull)
    |-> !o_wake_pin_out)
    else $error("open-drain wake pin drives high");
  AST_WAKE_GATE: assert property (!i_wake_pin_push_pull && !i_wake_pin_active_high
    && !o_wake_pin_oe_n |-> gwen_q || $past(gwen_q))
    else $error("wake pin active without global enable");

  COV_SERIRQ: cover property (o_serirq_slot2);
  COV_IRQ_PIN: cover property (!o_irq_pin_oe_n && !i_irq_pin_push_pull);
  COV_WAKE_PIN: cover property (!o_wake_pin_oe_n);
endmodule : agg_checker

bind smi_pme_wake_event_aggregator agg_checker chk (.*);

`default_nettype wire

// ---- bench/host_side_model.sv ----
// host side: pulled-up irq and wake lines, and a keyboard sending frames
// assumes the bench clock at 10 MHz; tasks are called from the bench
`timescale 1ns/1ns
`default_nettype none

module host_side_model (
  input  wire logic i_clk,
  input  wire logic i_irq_out,
  input  wire logic i_irq_oe_n,
  input  wire logic i_wake_out,
  input  wire logic i_wake_oe_n,
  output logic      o_irq_wire,
  output logic      o_wake_wire,
  output var logic  o_kb_clk,
  output var logic  o_kb_data
);
  // released lines float up to the pull-up
  assign o_irq_wire  = i_irq_oe_n ? 1'b1 : i_irq_out;
  assign o_wake_wire = i_wake_oe_n ? 1'b1 : i_wake_out;

  initial begin
    o_kb_clk  = 1'b1;
    o_kb_data = 1'b1;
  end

  task automatic kb_level(input logic v);
    o_kb_data <= v;
  endtask : kb_level

  // clock phases span more than one slow tick but less than the idle abort
  task automatic send_frame(input logic [7:0] code, input logic bad_par);
    logic [10:0] bits;
    bits = {1'b1, ~^code ^ bad_par, code, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge i_clk);
      o_kb_data <= bits[i];
      repeat (400) @(posedge i_clk);
      o_kb_clk <= 1'b0;
      repeat (400) @(posedge i_clk);
      o_kb_clk <= 1'b1;
    end
    repeat (2000) @(posedge i_clk);
  endtask : send_frame
endmodule : host_side_model

`default_nettype wire

// ---- bench/test_smi_pme_wake_event_aggregator.sv ----
// self-checking bench for the interrupt and wake event aggregator
// assumes the host model and the bound checker are compiled with it
`include "wake_agg_map.svh"
`timescale 1ns/1ns
`default_nettype none

module test_smi_pme_wake_event_aggregator;
  logic        i_clk, i_rstn, i_standby_rstn, i_reg_wr, i_reg_rd, i_ir_irq;
  logic [7:0]  i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [14:0] i_periph_evt;
  logic [23:0] i_gpio_evt, i_pin_invert, i_pin_either_edge;
  logic        i_ring_indicator_one_n, i_ring_indicator_two_n, i_ir_frame_ok, i_kb_clk;
  logic        i_kb_data, i_mouse_data, i_fan_evt, i_ext_slow_clk, i_irq_pin_sel;
  logic        i_irq_pin_active_high, i_irq_pin_push_pull, i_wake_pin_sel;
  logic        i_wake_pin_active_high, i_wake_pin_push_pull, o_group_irq_internal;
  logic        o_irq_pin_out, o_irq_pin_oe_n, o_serirq_slot2, o_wake_pin_out, o_wake_pin_oe_n;
  logic        irq_wire, wake_wire;
  int          miscompares, n_compared;

  smi_pme_wake_event_aggregator uut (.*);

  host_side_model hs (.i_clk(i_clk), .i_irq_out(o_irq_pin_out), .i_irq_oe_n(o_irq_pin_oe_n),
    .i_wake_out(o_wake_pin_out), .i_wake_oe_n(o_wake_pin_oe_n), .o_irq_wire(irq_wire),
    .o_wake_wire(wake_wire), .o_kb_clk(i_kb_clk), .o_kb_data(i_kb_data));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // ***********
  // bench tasks
  // ***********
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_reg_wr    <= 1'b1;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hFF);
    @(posedge i_clk);
    i_reg_rd   <= 1'b1;
    i_reg_addr <= a;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    @(negedge i_clk);
    chk(o_reg_rdata & m, exp);
  endtask : rd

  // one event from wake source k, then back to idle
  task automatic src(input int k);
    @(posedge i_clk);
    case (k)
      0: i_ring_indicator_one_n <= 1'b0;
      1: i_ring_indicator_two_n <= 1'b0;
      2: i_ir_frame_ok <= 1'b1;
      3: hs.kb_level(1'b0);
      4: i_mouse_data <= 1'b0;
      default: i_fan_evt <= 1'b1;
    endcase
    @(posedge i_clk);
    {i_ring_indicator_one_n, i_ring_indicator_two_n, i_ir_frame_ok} <= 3'b110;
    {i_mouse_data, i_fan_evt} <= 2'b10;
    hs.kb_level(1'b1);
  endtask : src

  initial begin
    repeat (100000) @(posedge i_clk);
    miscompares++;
    $display("[FAIL] %0t run did not complete", $time);
    tally_and_finish();
  end

  // ********
  // sequence
  // ********
  initial begin
    {i_rstn, i_standby_rstn, i_reg_wr, i_reg_rd, i_ir_irq, i_fan_evt, i_ir_frame_ok} = 7'h00;
    {i_reg_addr, i_reg_wdata, i_periph_evt} = 31'h0;
    {i_gpio_evt, i_pin_invert, i_pin_either_edge} = 72'h0;
    {i_ring_indicator_one_n, i_ring_indicator_two_n, i_mouse_data, i_ext_slow_clk} = 4'hE;
    {i_irq_pin_sel, i_irq_pin_active_high, i_irq_pin_push_pull} = 3'h4;
    {i_wake_pin_sel, i_wake_pin_active_high, i_wake_pin_push_pull} = 3'h4;
    miscompares = 0;
    n_compared  = 0;
    cyc(10);
    i_rstn         <= 1'b1;
    i_standby_rstn <= 1'b1;
    cyc(3);
    chk({6'h00, irq_wire, wake_wire}, 8'h03);
    rd(8'h1C, `REG_RESET);
    rd(8'h5F, `KEY_CODE_RESET);
    rd(8'hF0, `CFG_RESET);
    wr(8'h40, 8'hFF);
    rd(8'h40, 8'h00);
    wr(8'h1B, 8'h01);
    @(posedge i_clk) i_periph_evt[0] <= 1'b1;
    cyc(4);
    chk(8'(o_group_irq_internal), 8'h01);
    wr(8'h13, 8'hFF);
    rd(8'h13, 8'h01);
    chk({6'h00, irq_wire, o_serirq_slot2}, 8'h02);
    wr(8'h1C, 8'h80);
    cyc(4);
    chk({6'h00, irq_wire, o_serirq_slot2}, 8'h00);
    wr(8'h1C, 8'h40);
    cyc(4);
    chk({6'h00, irq_wire, o_serirq_slot2}, 8'h03);
    @(posedge i_clk) {i_irq_pin_active_high, i_irq_pin_push_pull} <= 2'b11;
    wr(8'h1C, 8'h80);
    cyc(4);
    chk({6'h00, irq_wire, o_irq_pin_oe_n}, 8'h02);
    @(posedge i_clk) i_periph_evt[0] <= 1'b0;
    cyc(4);
    chk({6'h00, o_group_irq_internal, irq_wire}, 8'h00);
    @(posedge i_clk) {i_irq_pin_active_high, i_irq_pin_push_pull} <= 2'b00;
    wr(8'h1C, 8'h00);
    @(posedge i_clk) i_ir_irq <= 1'b1;
    @(posedge i_clk) i_ir_irq <= 1'b0;
    cyc(4);
    rd(8'h14, 8'h01);
    rd(8'h14, 8'h00);
    wr(8'h1D, 8'h01);
    wr(8'h0C, 8'h01);
    for (int m = 0; m < 3; m++) begin
      @(posedge i_clk);
      i_pin_invert[0]      <= (m == 1);
      i_pin_either_edge[0] <= (m == 2);
      cyc(6);
      wr(8'h15, 8'hFF);
      wr(8'h04, 8'hFF);
      @(posedge i_clk) i_gpio_evt[0] <= 1'b1;
      cyc(6);
      rd(8'h15, 8'(m != 1));
      rd(8'h04, 8'(m != 1));
      chk(8'(o_group_irq_internal), 8'(m != 1));
      wr(8'h15, 8'hFF);
      wr(8'h04, 8'hFF);
      rd(8'h15, 8'h00);
      @(posedge i_clk) i_gpio_evt[0] <= 1'b0;
      cyc(6);
      rd(8'h15, 8'(m != 0));
      rd(8'h04, 8'(m != 0));
      wr(8'h15, 8'hFF);
      wr(8'h04, 8'hFF);
    end
    wr(8'h1D, 8'h00);
    wr(8'h0C, 8'h00);
    wr(8'h00, 8'h01);
    for (int k = 0; k < 7; k++) begin
      if (k != 5) begin
        wr(8'h0B, 8'(1 << k));
        src(k);
        cyc(6);
        rd(8'h03, 8'(1 << k));
        rd(8'h00, 8'h01);
        chk(8'(wake_wire), 8'h01);
        wr(8'h00, 8'h01);
        rd(8'h00, 8'h01);
        wr(8'h03, 8'hFF);
        wr(8'h00, 8'h01);
        rd(8'h00, 8'h00);
      end
    end
    wr(8'h01, 8'h01);
    wr(8'h0B, 8'h01);
    src(0);
    cyc(6);
    chk(8'(wake_wire), 8'h00);
    wr(8'h03, 8'hFF);
    wr(8'h00, 8'h01);
    cyc(4);
    chk(8'(wake_wire), 8'h01);
    wr(8'h0B, 8'h00);
    wr(8'h0D, 8'h08);
    @(posedge i_clk) i_periph_evt[0] <= 1'b1;
    cyc(6);
    rd(8'h05, 8'h00);
    wr(8'h1C, 8'h20);
    cyc(6);
    rd(8'h05, 8'h08);
    chk(8'(wake_wire), 8'h00);
    @(posedge i_clk) {i_wake_pin_active_high, i_wake_pin_push_pull} <= 2'b11;
    cyc(2);
    chk({6'h00, o_wake_pin_out, o_wake_pin_oe_n}, 8'h02);
    @(posedge i_clk) {i_wake_pin_active_high, i_wake_pin_push_pull} <= 2'b00;
    @(posedge i_clk) i_periph_evt[0] <= 1'b0;
    cyc(4);
    wr(8'h05, 8'h08);
    wr(8'h00, 8'h01);
    cyc(4);
    rd(8'h05, 8'h00);
    chk(8'(wake_wire), 8'h01);
    wr(8'h1C, 8'h00);
    wr(8'h0D, 8'h00);
    wr(8'hF0, 8'h03);
    rd(8'hF0, 8'h03);
    wr(8'hF0, 8'h00);
    wr(8'h5F, 8'hA7);
    wr(8'h0B, 8'h20);
    hs.send_frame(8'hA7, 1'b0);
    rd(8'h03, 8'h20, 8'h20);
    chk(8'(wake_wire), 8'h00);
    wr(8'h03, 8'hFF);
    wr(8'h00, 8'h01);
    hs.send_frame(8'hA7, 1'b1);
    rd(8'h03, 8'h00, 8'h20);
    hs.send_frame(8'h5A, 1'b0);
    rd(8'h03, 8'h00, 8'h20);
    wr(8'hF0, 8'h01);
    hs.send_frame(8'hA7, 1'b0);
    rd(8'h03, 8'h00, 8'h20);
    wr(8'hF0, 8'h02);
    hs.send_frame(8'hA7, 1'b0);
    rd(8'h03, 8'h00, 8'h20);
    @(posedge i_clk) i_rstn <= 1'b0;
    cyc(3);
    i_rstn <= 1'b1;
    cyc(3);
    rd(8'h5F, 8'hA7);
    @(posedge i_clk) i_standby_rstn <= 1'b0;
    cyc(3);
    i_standby_rstn <= 1'b1;
    cyc(3);
    rd(8'h5F, `KEY_CODE_RESET);
    tally_and_finish();
  end
endmodule : test_smi_pme_wake_event_aggregator

`default_nettype wire
